/* verilog/crs_reader.sv */
// Purpose: Card reader synchronizer: spec fetch, card cycle, image store.
// Assumes: Mechanism pins are asynchronous and held stable around toggles.
// Notes:   Memory never stalls; one word write per mem_wr pulse.
//
// The address-and-strobe port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ns

module crs_reader
(
	// Clock and reset
	input  wire logic              clock,
	input  wire logic              reset,
	// Register port
	input  wire logic [7:0]        reg_addr,
	input  wire logic [31:0]       reg_wdata,
	input  wire logic              reg_wr,
	input  wire logic              reg_rd,
	output logic      [31:0]       reg_rdata,
	// Card mechanism
	input  wire crs_pkg::crs_mech_s mech,
	output logic                   feed_pulse,
	output logic                   translate,
	output logic      [1:0]        stacker_sel,
	output logic                   misfeed_lamp,
	output logic                   stack_full_lamp,
	// Memory write port
	output logic                   mem_wr,
	output logic      [14:0]       mem_addr,
	output logic      [24:0]       mem_data,
	// Program interrupt request
	output logic                   irq_req
);
	typedef struct packed {
		crs_pkg::crs_mech_s  sync1;
		crs_pkg::crs_mech_s  sync2;
		logic                win_p;
		logic                sense_p;
		logic                row_p;
		logic                word_p;
		logic                flt_p;
		logic                mis_p;
		logic                full_p;
		crs_pkg::crs_phase_e phase;
		logic [25:0]         sb_fs;
		logic [1:0]          sb_res;
		logic                sb_set;
		logic [25:0]         cur_fs;
		crs_pkg::crs_ind_s   ind;
		logic                fetched;
		logic                cyc_abn;
		logic                chk_err;
		logic                derr_pend;
		logic                supp;
		logic                col90;
		logic                halted;
		logic [4:0]          rows;
		logic [5:0]          words;
		logic [11:0]         hole1;
		logic [11:0]         hole2;
		logic [11:0]         hole1_prev;
		logic                mem_wr;
		logic [14:0]         mem_addr;
		logic [24:0]         mem_data;
		logic                feed;
		logic [1:0]          stk;
		logic                full_lamp;
		logic                irq;
		logic [31:0]         rdata;
	} crs_state_s;
	crs_state_s         r_q;
	crs_state_s         r_d;
	crs_pkg::crs_mech_s s;
	crs_pkg::crs_ind_s  setv;
	crs_pkg::crs_ind_s  clr;
	logic               win_rise;
	logic               win_fall;
	logic               sense_rise;
	logic               sense_fall;
	logic               row_evt;
	logic               word_evt;
	logic               flt_rise;
	logic               mis_rise;
	logic               full_rise;
	logic               in_use;
	logic               inhibit;
	logic               fetch_go;
	logic               call_err;
	logic               sb_write;
	logic               st_write;
	logic [5:0]         due;
	logic [24:0]        img;
	// Residue of a value: bit weights alternate 1 and 2 modulo three
	function automatic logic [1:0] mod3(input logic [25:0] v);
		int acc;
		acc = 0;
		for (int i = 0; i < 26; i++)
			acc = acc + (v[i] ? (i % 2) + 1 : 0);
		mod3 = 2'(acc % 3);
	endfunction
	function automatic logic [5:0] words_due(input logic col90,
		input logic xlat);
		if (col90)
			words_due = crs_pkg::WORDS_90;
		else if (xlat)
			words_due = crs_pkg::WORDS_XLAT80;
		else
			words_due = crs_pkg::WORDS_RAW80;
	endfunction
	// Code 11 is undefined; it falls back to stacker zero
	function automatic logic [1:0] stk_decode(input logic [1:0] code);
		if (code == crs_pkg::STK1)
			stk_decode = crs_pkg::STK1;
		else if (code == crs_pkg::STK2)
			stk_decode = crs_pkg::STK2;
		else
			stk_decode = crs_pkg::STK0;
	endfunction
	assign s          = r_q.sync2;
	assign win_rise   = s.window & ~r_q.win_p;
	assign win_fall   = ~s.window & r_q.win_p;
	assign sense_rise = s.sense & ~r_q.sense_p;
	assign sense_fall = ~s.sense & r_q.sense_p;
	assign row_evt    = s.row_tgl ^ r_q.row_p;
	assign word_evt   = s.word_tgl ^ r_q.word_p;
	assign flt_rise   = s.fault & ~r_q.flt_p;
	assign mis_rise   = (s.empty | s.misfeed) & ~r_q.mis_p;
	assign full_rise  = (|s.stk_full) & ~r_q.full_p;
	assign in_use     = r_q.sb_set | s.in_path;
	assign inhibit    = r_q.ind.data_err | r_q.ind.fault;
	assign fetch_go   = (r_q.phase == crs_pkg::PH_TEST) & r_q.sb_set
		& ~r_q.fetched;
	assign call_err   =
		(|r_q.sb_fs[crs_pkg::FS_ZERO_HI:crs_pkg::FS_ZERO_LO])
		| (mod3(r_q.sb_fs) != r_q.sb_res);
	assign sb_write   = reg_wr & (reg_addr == crs_pkg::REG_STANDBY);
	assign st_write   = reg_wr & (reg_addr == crs_pkg::REG_STATUS);
	assign due        = words_due(r_q.col90, r_q.cur_fs[crs_pkg::FS_XLAT]);
	// Image word: sign cleared, tail characters trimmed on 90 columns
	always_comb
	begin
		img = {1'b0, s.word};
		if (r_q.col90 && (r_q.words == crs_pkg::W90_MID
			|| r_q.words == crs_pkg::W90_END))
			img[crs_pkg::CHAR_W * crs_pkg::ZERO_CHARS - 1:0] = '0;
	end
	always_comb
	begin
		r_d = r_q;
		setv = '0;
		clr = '0;
		r_d.sync1 = mech;
		r_d.sync2 = r_q.sync1;
		r_d.win_p = s.window;
		r_d.sense_p = s.sense;
		r_d.row_p = s.row_tgl;
		r_d.word_p = s.word_tgl;
		r_d.flt_p = s.fault;
		r_d.mis_p = s.empty | s.misfeed;
		r_d.full_p = |s.stk_full;
		r_d.full_lamp = |s.stk_full;
		r_d.mem_wr = 1'b0;
		r_d.feed = 1'b0;
		r_d.irq = 1'b0;
		r_d.rdata = '0;
		// Halt holds until oversight is cleared and the feed is healthy
		r_d.halted = r_q.halted
			& (r_q.ind.oversight | s.empty | s.misfeed);
		// Abnormal conditions only count with work pending
		if (flt_rise && in_use)
		begin
			setv.fault = 1'b1;
			r_d.cyc_abn = 1'b1;
		end
		if (mis_rise && in_use)
		begin
			r_d.halted = 1'b1;
			setv.oversight = ~setv.fault;
			r_d.cyc_abn = 1'b1;
		end
		if (full_rise && in_use)
		begin
			setv.oversight = ~setv.fault;
			r_d.cyc_abn = 1'b1;
		end
		case (r_q.phase)
			crs_pkg::PH_CHECK:
			begin
				if (win_rise)
				begin
					r_d.phase = crs_pkg::PH_TEST;
					r_d.fetched = 1'b0;
					r_d.cyc_abn = 1'b0;
					r_d.derr_pend = 1'b0;
					// Abnormal event in the ending cycle wins
					if (r_q.derr_pend && !r_q.cyc_abn)
						setv.data_err = 1'b1;
				end
			end
			crs_pkg::PH_TEST:
			begin
				if (fetch_go)
				begin
					r_d.cur_fs = r_q.sb_fs;
					r_d.sb_set = 1'b0;
					r_d.fetched = 1'b1;
					if (r_q.sb_fs[crs_pkg::FS_IRQ])
						setv.initiation = 1'b1;
					if (call_err)
						setv.fault = 1'b1;
				end
				if (win_fall)
				begin
					// Past point B no spec is taken this cycle
					r_d.phase = crs_pkg::PH_WAIT_C;
					if (r_q.fetched)
					begin
						r_d.stk = stk_decode(r_q.cur_fs[
							crs_pkg::FS_STK_HI:crs_pkg::FS_STK_LO]);
						r_d.feed = r_q.cur_fs[crs_pkg::FS_FEED]
							& ~r_q.halted;
					end
					else
						r_d.stk = crs_pkg::STK0;
				end
			end
			crs_pkg::PH_WAIT_C:
			begin
				if (sense_rise)
				begin
					r_d.phase = crs_pkg::PH_SENSE;
					r_d.rows = '0;
					r_d.words = '0;
					r_d.hole1 = '0;
					r_d.hole2 = '0;
					r_d.chk_err = 1'b0;
				end
			end
			crs_pkg::PH_SENSE:
			begin
				if (row_evt)
				begin
					r_d.rows = r_q.rows + 5'h01;
					r_d.hole1 = r_q.hole1 + 12'(s.holes1);
					r_d.hole2 = r_q.hole2 + 12'(s.holes2);
				end
				// Station two only; stops at the due count
				if (word_evt && s.card_at2 && !inhibit
					&& r_q.words < due)
				begin
					r_d.mem_wr = 1'b1;
					r_d.mem_addr = r_q.cur_fs[
						crs_pkg::FS_L_HI:crs_pkg::FS_L_LO]
						+ 15'(r_q.words);
					r_d.mem_data = img;
					r_d.words = r_q.words + 6'h01;
					if (mod3({2'h0, s.word}) != s.res)
						r_d.chk_err = 1'b1;
				end
				if (sense_fall)
				begin
					r_d.phase = crs_pkg::PH_CHECK;
					r_d.hole1_prev = r_d.hole1;
					if (s.card_at2)
						r_d.derr_pend = r_d.chk_err
							| (r_q.hole1_prev != r_d.hole2)
							| (!inhibit && r_d.words != due);
				end
			end
			default:
				r_d.phase = crs_pkg::PH_CHECK;
		endcase
		// Register port
		if (st_write)
		begin
			clr.initiation = reg_wdata[crs_pkg::ST_INIT];
			clr.data_err = reg_wdata[crs_pkg::ST_DERR];
			clr.fault = reg_wdata[crs_pkg::ST_FAULT];
			clr.oversight = reg_wdata[crs_pkg::ST_OVS];
		end
		else if (sb_write)
		begin
			r_d.sb_fs = reg_wdata[crs_pkg::FS_W - 1:0];
			r_d.sb_res = reg_wdata[crs_pkg::FS_RES_LO + 1:
				crs_pkg::FS_RES_LO];
			r_d.sb_set = 1'b1;
		end
		else if (reg_wr && reg_addr == crs_pkg::REG_CONTROL)
		begin
			r_d.supp = reg_wdata[crs_pkg::CT_SUPP];
			r_d.col90 = reg_wdata[crs_pkg::CT_COL90];
		end
		if (reg_rd)
		begin
			if (reg_addr == crs_pkg::REG_STANDBY)
				r_d.rdata = {r_q.sb_res, 4'h0, r_q.sb_fs};
			else if (reg_addr == crs_pkg::REG_STATUS)
				r_d.rdata = {24'h0, inhibit, r_q.halted,
					r_q.phase == crs_pkg::PH_SENSE,
					r_q.ind.oversight, r_q.ind.fault,
					r_q.ind.data_err, r_q.ind.initiation,
					r_q.sb_set};
			else if (reg_addr == crs_pkg::REG_CONTROL)
				r_d.rdata = {30'h0, r_q.col90, r_q.supp};
			else if (reg_addr == crs_pkg::REG_CURRENT)
				r_d.rdata = {6'h0, r_q.cur_fs};
			else if (reg_addr == crs_pkg::REG_COUNTS)
				r_d.rdata = {11'h0, r_q.rows, 10'h0, r_q.words};
		end
		// Set wins over a clear in the same cycle
		r_d.ind = (r_q.ind & ~clr) | setv;
		r_d.irq = (|setv) & ~r_q.supp;
	end

	always_ff @(posedge clock)
	begin
		if (reset)
		begin
			r_q <= '0;
			r_q.supp <= crs_pkg::CTRL_RST[crs_pkg::CT_SUPP];
			r_q.col90 <= crs_pkg::CTRL_RST[crs_pkg::CT_COL90];
		end
		else
			r_q <= r_d;
	end
	assign reg_rdata = r_q.rdata;
	assign feed_pulse = r_q.feed;
	assign translate = r_q.cur_fs[crs_pkg::FS_XLAT];
	assign stacker_sel = r_q.stk;
	assign misfeed_lamp = r_q.halted;
	assign stack_full_lamp = r_q.full_lamp;
	assign mem_wr = r_q.mem_wr;
	assign mem_addr = r_q.mem_addr;
	assign mem_data = r_q.mem_data;
	assign irq_req = r_q.irq;
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (reset);
	a_fetch_clears: assert property (fetch_go && !sb_write
		|=> !r_q.sb_set && r_q.fetched)
		else $error("standby not consumed by fetch");
	a_init_flag: assert property (fetch_go && r_q.sb_fs[16]
		|=> r_q.ind.initiation ##1 r_q.ind.initiation || $past(st_write))
		else $error("initiation not raised");
	a_call_fault: assert property (fetch_go && call_err
		|=> r_q.ind.fault)
		else $error("spec call error missed");
	a_late_fetch: assert property (r_q.phase != crs_pkg::PH_TEST
		|=> $stable(r_q.cur_fs))
		else $error("spec taken outside window");
	a_sign_zero: assert property (r_q.mem_wr |-> !r_q.mem_data[24])
		else $error("sign bit written");
	a_word_place: assert property (r_q.mem_wr |-> r_q.words != 6'h00
		&& r_q.words <= due && r_q.mem_addr == r_q.cur_fs[15:1]
		+ 15'(r_q.words - 6'h01))
		else $error("image word out of place");
	a_stk_zero: assert property (r_q.phase == crs_pkg::PH_TEST
		&& win_fall && !r_q.fetched |=> r_q.stk == 2'h0)
		else $error("unspecified card not to stacker zero");
	a_mem_lock: assert property (inhibit |=> !r_q.mem_wr)
		else $error("memory accessed while locked");
	a_irq_supp: assert property (r_q.supp |=> !r_q.irq)
		else $error("interrupt while suppressed");
	a_sticky_flt: assert property (r_q.ind.fault && !(st_write
		&& reg_wdata[3]) |=> r_q.ind.fault)
		else $error("fault dropped without clear");
	a_no_feed: assert property (r_q.phase == crs_pkg::PH_TEST && win_fall
		&& !r_q.cur_fs[17] |=> !r_q.feed)
		else $error("feed without feed bit");
	c_fetch_irq: cover property (fetch_go && r_q.sb_fs[16] ##1 r_q.irq);
	c_mem_write: cover property (r_q.mem_wr);
	c_data_err: cover property ($rose(r_q.ind.data_err));
	c_feed: cover property (r_q.feed);

endmodule

/* verilog/crs_pkg.sv */
// Purpose: Shared constants and types for the card reader synchronizer.
// Assumes: Spec word bit n sits at vector index n; index 0 is unused.
// Notes:   Offsets are byte addresses on the plain register port.
package crs_pkg;

	// Register offsets
	localparam logic [7:0] REG_STANDBY = 8'h00;
	localparam logic [7:0] REG_STATUS  = 8'h04;
	localparam logic [7:0] REG_CONTROL = 8'h08;
	localparam logic [7:0] REG_CURRENT = 8'h0C;
	localparam logic [7:0] REG_COUNTS  = 8'h10;

	// Spec word fields
	localparam int FS_W       = 26;
	localparam int FS_L_LO    = 1;
	localparam int FS_L_HI    = 15;
	localparam int FS_IRQ     = 16;
	localparam int FS_FEED    = 17;
	localparam int FS_XLAT    = 18;
	localparam int FS_STK_LO  = 19;
	localparam int FS_STK_HI  = 20;
	localparam int FS_ZERO_LO = 21;
	localparam int FS_ZERO_HI = 25;
	localparam int FS_RES_LO  = 30;

	// Status register bits
	localparam int ST_STANDBY = 0;
	localparam int ST_INIT    = 1;
	localparam int ST_DERR    = 2;
	localparam int ST_FAULT   = 3;
	localparam int ST_OVS     = 4;
	localparam int ST_SENSE   = 5;
	localparam int ST_HALT    = 6;
	localparam int ST_INHIB   = 7;

	// Control register bits and reset value
	localparam int CT_SUPP = 0;
	localparam int CT_COL90 = 1;
	localparam logic [1:0] CTRL_RST = 2'h0;

	// Card image layout
	localparam int WORD_W    = 25;
	localparam int SIGN_BIT  = 24;
	localparam int CHAR_W    = 6;
	localparam int ZERO_CHARS = 3;
	localparam logic [5:0] WORDS_XLAT80 = 6'h14;
	localparam logic [5:0] WORDS_RAW80  = 6'h28;
	localparam logic [5:0] WORDS_90     = 6'h18;
	localparam logic [5:0] W90_MID      = 6'h0B;
	localparam logic [5:0] W90_END      = 6'h17;

	// Stacker codes
	localparam logic [1:0] STK0 = 2'h0;
	localparam logic [1:0] STK1 = 2'h1;
	localparam logic [1:0] STK2 = 2'h2;

	typedef enum logic [1:0] {PH_CHECK, PH_TEST, PH_WAIT_C, PH_SENSE}
		crs_phase_e;

	// Card mechanism pins
	typedef struct packed {
		logic        window;
		logic        sense;
		logic        row_tgl;
		logic        word_tgl;
		logic        empty;
		logic        misfeed;
		logic [2:0]  stk_full;
		logic        fault;
		logic        in_path;
		logic        card_at2;
		logic [7:0]  holes1;
		logic [7:0]  holes2;
		logic [23:0] word;
		logic [1:0]  res;
	} crs_mech_s;

	typedef struct packed {
		logic initiation;
		logic data_err;
		logic fault;
		logic oversight;
	} crs_ind_s;

endpackage

/* bench/crs_mech_model.sv */
// Purpose: Behavioural card mechanism facing the synchronizer.
// Assumes: Pins change after a rising edge and hold 4 clocks.
// Notes:   Hole counts stay zero, so no check-read error arises.
`timescale 1ns/1ns
module crs_mech_model
(
	// Clock
	input  wire logic          clock,
	// Mechanism pins
	output crs_pkg::crs_mech_s mech
);
	initial
	begin
		mech = '0;
		mech.in_path = 1'b1;
		mech.card_at2 = 1'b1;
	end
	task automatic wt(input int n);
		repeat (n) @(posedge clock);
	endtask
	task automatic abn(input logic e, input logic [2:0] f);
		@(posedge clock);
		mech.empty <= e;
		mech.stk_full <= f;
	endtask
	// Window A..B, then sense C..D carrying rows and words
	task automatic cycle(input int nw, input int bad);
		logic [23:0] w;
		mech.window <= 1'b1;
		wt(12);
		mech.window <= 1'b0;
		wt(6);
		mech.sense <= 1'b1;
		for (int k = 0; k < nw; k++)
		begin
			w = 24'($urandom);
			wt(1);
			mech.word <= w;
			// A wrong residue models a corrupted word
			mech.res <= 2'(w % 3) ^ {1'b0, k == bad};
			wt(4);
			mech.word_tgl <= ~mech.word_tgl;
			wt(4);
			mech.row_tgl <= ~mech.row_tgl;
			wt(4);
		end
		mech.sense <= 1'b0;
		wt(8);
	endtask
endmodule

/* bench/tb_card_reader_synchronizer.sv */
// Purpose: Self-checking bench for the card reader synchronizer.
// Assumes: Register map and timing as handed over with the design.
// Notes:   Image contents are not compared, only placement, sign and trim.
`timescale 1ns/1ns
module tb_card_reader_synchronizer;
	logic               clock, reset, reg_wr, reg_rd, irq, col90;
	logic               feed_pulse, translate, misfeed_lamp;
	logic               stack_full_lamp, mem_wr, irq_req;
	logic [7:0]         reg_addr;
	logic [31:0]        reg_wdata, reg_rdata, rd;
	logic [1:0]         stacker_sel;
	logic [14:0]        mem_addr, base, nb;
	logic [24:0]        mem_data;
	logic [3:0]         code;
	crs_pkg::crs_mech_s mech;
	int                 error_cnt, num_checks, cyc, nwr, nirq, nfeed;

	crs_reader dut (.clock(clock), .reset(reset), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .mech(mech), .feed_pulse(feed_pulse),
		.translate(translate), .stacker_sel(stacker_sel),
		.misfeed_lamp(misfeed_lamp), .stack_full_lamp(stack_full_lamp),
		.mem_wr(mem_wr), .mem_addr(mem_addr), .mem_data(mem_data),
		.irq_req(irq_req));
	crs_mech_model mdl (.clock(clock), .mech(mech));

	task automatic check(input logic [31:0] s, e, input string m);
		num_checks++;
		if (s !== e)
		begin
			error_cnt++;
			$display("wrong value at %0t: %s %h not %h", $time, m, s, e);
		end
	endtask
	task automatic tally_and_finish();
		$display("errors %0d checks %0d", error_cnt, num_checks);
		if (error_cnt == 0 && num_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clock);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clock);
		reg_wr <= 1'b0;
	endtask
	task automatic rdr(input logic [7:0] a);
		@(posedge clock);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clock);
		reg_rd <= 1'b0;
		// Read data stand in the cycle after the strobe
		@(posedge clock);
		rd = reg_rdata;
	endtask
	function automatic logic [31:0] spec(input logic [3:0] c,
		input logic i, input logic [14:0] b);
		logic [25:0] s;
		s = {5'h00, c, i, b, 1'b0};
		return {2'(s % 3), 4'h0, s};
	endfunction
	function automatic logic [31:0] due(input logic [3:0] c);
		return col90 ? 32'h18 : (c[1] ? 32'h14 : 32'h28);
	endfunction
	function automatic logic [31:0] stk(input logic [3:0] c);
		return (c[3:2] == 2'h3) ? 32'h0 : {30'h0, c[3:2]};
	endfunction
	task automatic run(input int nw, input int bad);
		nwr = 0;
		nirq = 0;
		nfeed = 0;
		mdl.cycle(nw, bad);
	endtask
	task automatic go(input logic [3:0] c, input logic i, input int n);
		base = 15'($urandom % 512) << 6;
		wr(crs_pkg::REG_STANDBY, spec(c, i, base));
		rdr(crs_pkg::REG_STATUS);
		check(rd & 32'h1, 32'h1, "standby");
		run(n, -1);
	endtask

	// Placement and trimming of every stored word
	always @(posedge clock)
	begin
		if (mem_wr === 1'b1)
		begin
			check({17'h0, mem_addr}, {17'h0, base + 15'(nwr)}, "addr");
			check({31'h0, mem_data[24]}, 32'h0, "sign");
			if (col90 && (nwr == 11 || nwr == 23))
				check({14'h0, mem_data[17:0]}, 32'h0, "trim");
			nwr++;
		end
		nirq += (irq_req === 1'b1);
		nfeed += (feed_pulse === 1'b1);
	end

	// Ceiling well above the longest expected run
	initial
	begin
		cyc = 0;
		while (cyc < 40000)
		begin
			@(posedge clock);
			cyc++;
		end
		error_cnt++;
		tally_and_finish();
	end
	initial
	begin
		clock = 1'b0;
		forever #20 clock = ~clock;
	end
	initial
	begin
		reset = 1'b1;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 32'h0;
		col90 = 1'b0;
		base = 15'h0;
		void'($urandom(32'h2DB1));
		repeat (3) @(posedge clock);
		reset <= 1'b0;
		rdr(crs_pkg::REG_STATUS);
		check(rd, 32'h0, "status");
		rdr(crs_pkg::REG_CONTROL);
		check(rd, 32'h0, "control");
		rdr(8'h3C);
		check(rd, 32'h0, "unmapped");
		// Codes 12..15 first, so the last spec is feed, translate, stacker 2
		for (int c = 0; c < 16; c++)
		begin
			code = 4'(c + 12);
			irq = 1'($urandom);
			go(code, irq, due(code));
			rdr(crs_pkg::REG_STATUS);
			check(rd & 32'h3, {30'h0, irq, 1'b0}, "init");
			check(nirq, {31'h0, irq}, "irq");
			check(nfeed, {31'h0, code[0]}, "feed");
			check(nwr, due(code), "words");
			check({30'h0, stacker_sel}, stk(code), "stacker");
			check({31'h0, translate}, {31'h0, code[1]}, "xlat");
			wr(crs_pkg::REG_STATUS, 32'h2);
		end
		// No spec in time: old area and format, stacker zero
		nb = 15'h0240;
		fork
			run(32'h14, -1);
			begin
				repeat (40) @(posedge clock);
				wr(crs_pkg::REG_STANDBY, spec(4'h4, 1'b1, nb));
			end
		join
		check(nwr, 32'h14, "stale");
		check({30'h0, stacker_sel}, 32'h0, "nospec");
		rdr(crs_pkg::REG_STATUS);
		check(rd & 32'h1, 32'h1, "late");
		// Suppressed interrupts, 90 columns, last word corrupted
		wr(crs_pkg::REG_CONTROL, 32'h3);
		col90 = 1'b1;
		base = nb;
		run(24, 23);
		check(nirq, 32'h0, "supp");
		check({30'h0, stacker_sel}, 32'h1, "stk1");
		rdr(crs_pkg::REG_STATUS);
		check(rd & 32'h7, 32'h2, "defer");
		wr(crs_pkg::REG_STATUS, 32'h2);
		wr(crs_pkg::REG_CONTROL, 32'h2);
		// Error flagged at next start, spec still runs, memory locked
		go(4'h0, 1'b1, 24);
		check(nwr, 32'h0, "locked");
		rdr(crs_pkg::REG_STATUS);
		check(rd & 32'h87, 32'h86, "derr");
		check(32'(nirq > 0), 32'h1, "derr irq");
		rdr(crs_pkg::REG_STATUS);
		check(rd & 32'h86, 32'h86, "held");
		wr(crs_pkg::REG_STATUS, 32'h6);
		rdr(crs_pkg::REG_STATUS);
		check(rd & 32'h84, 32'h0, "clear");
		// Spec with a bad residue
		wr(crs_pkg::REG_STANDBY, spec(4'h0, 1'b1, nb) ^ 32'h4000_0000);
		run(24, -1);
		rdr(crs_pkg::REG_STATUS);
		check(rd & 32'hA, 32'hA, "fault");
		wr(crs_pkg::REG_STATUS, 32'h1E);
		// Empty magazine, then a full stacker
		nirq = 0;
		mdl.abn(1'b1, 3'h0);
		mdl.wt(8);
		check({31'h0, misfeed_lamp}, 32'h1, "lamp");
		rdr(crs_pkg::REG_STATUS);
		check(rd & 32'h50, 32'h50, "halt");
		check(32'(nirq > 0), 32'h1, "ovs irq");
		mdl.abn(1'b0, 3'h4);
		mdl.wt(8);
		check({31'h0, stack_full_lamp}, 32'h1, "full");
		tally_and_finish();
	end
endmodule
